// File: encoder_pin_access_lock.sv
// Purpose: PIN access lock for a remote-control encoder
// Assumes: Single 100 MHz clock, key exchange done elsewhere
// Notes:   Function
`timescale 1ns/1ps
`default_nettype none
module encoder_pin_access_lock
    import pin_lock_pkg::*;
#(
    parameter int unsigned     DEB_CYC    = DEBOUNCE_CYC,
    parameter int unsigned     FLASH_CYC  = FLASH_HALF_CYC,
    // Cycles per second; every second-scale timer below follows it
    parameter int unsigned     SEC_CYC    = CLK_HZ,
    parameter int unsigned     IND_CYC    = IND_ON_S * SEC_CYC,
    parameter int unsigned     SETUP_CYC  = SETUP_WIN_S * SEC_CYC,
    parameter int unsigned     GAP_CYC    = ENTRY_GAP_S * SEC_CYC,
    parameter longint unsigned LONG_CYC   = 64'(LOCK_LONG_S) * 64'(SEC_CYC),
    parameter int unsigned     SHORT_CYC  = LOCK_SHORT_S * SEC_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              pin_setup_req,
    input  wire logic              transmit_req,
    input  wire logic              lockout_sel,
    input  wire logic              key_learned,
    input  wire logic              key_exchange_ok,
    output var  logic              status_indicator,
    output var  logic              transmit_enable,
    output var  logic              unlocked,
    output var  logic              pin_stored
);
    // Every timer must be nonzero and fit the 40-bit counters
    if (FLASH_CYC < 1 || IND_CYC < 1 || SETUP_CYC < 1 || GAP_CYC < 1 || SHORT_CYC < 1 ||
        LONG_CYC < 1 || LONG_CYC > 64'h0000_00ff_ffff_ffff) begin : g_bad_timer
        $error("Timer counts must lie between 1 and 2**40-1");
    end

    localparam int unsigned TW = 40;
    localparam int unsigned EW = $clog2(PIN_LEN + 1);
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ENTRY, ST_OPEN} lock_state_t;

    key_events_t              ev;
    logic [DATA_W-1:0]        data_lvl;
    logic                     setup_lvl;
    logic                     tx_s1_reg, tx_s2_reg, sel_s1_reg, sel_s2_reg;
    logic                     kl_s1_reg, kl_s2_reg, ko_s1_reg, ko_s2_reg, ko_d_reg;

    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_data
            input_conditioner #(.DEB_CYC(DEB_CYC)) u_cond (
                .ref_clk (ref_clk),
                .reset_n (reset_n),
                .pin_in  (data_in[gi]),
                .level   (data_lvl[gi]),
                .fall    (ev.data_fall[gi])
            );
        end
    endgenerate
    input_conditioner #(.DEB_CYC(DEB_CYC)) u_setup_cond (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .pin_in  (pin_setup_req),
        .level   (setup_lvl),
        .fall    (ev.setup_fall)
    );

    function automatic logic [2:0] first_index(input logic [DATA_W-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (v[i]) r = 3'(i);
        end
        return r;
    endfunction : first_index

    lock_state_t              state_reg, state_next;
    logic [TW-1:0]            tmr_reg, tmr_next;
    logic [TW-1:0]            ind_tmr_reg, ind_tmr_next;
    logic [TW-1:0]            fl_tmr_reg, fl_tmr_next;
    logic [EW-1:0]            cnt_reg, cnt_next;
    logic [PIN_LEN*3-1:0]     pin_reg, pin_next, buf_reg, buf_next;
    logic                     stored_reg, stored_next, flash_reg, flash_next;
    logic                     ind_reg, ind_next, txen_reg, txen_next, unl_reg, unl_next;
    logic                     any_fall, data_busy, learn_ev, ok_ev;
    logic [TW-1:0]            lock_lim;

    assign any_fall  = |ev.data_fall;
    assign data_busy = |data_lvl;
    assign learn_ev  = kl_s2_reg;
    assign ok_ev     = ko_s2_reg & ~ko_d_reg;
    assign lock_lim  = sel_s2_reg ? TW'(SHORT_CYC) : TW'(LONG_CYC);

    always_comb begin
        state_next   = state_reg;
        tmr_next     = tmr_reg + 1'b1;
        cnt_next     = cnt_reg;
        pin_next     = pin_reg;
        buf_next     = buf_reg;
        stored_next  = stored_reg;
        unl_next     = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                tmr_next = '0;
                if (ev.setup_fall) begin
                    state_next = ST_SETUP;
                    cnt_next   = '0;
                end else if (stored_reg && any_fall) begin
                    state_next = ST_ENTRY;
                    buf_next   = {first_index(ev.data_fall), buf_reg[PIN_LEN*3-1:3]};
                    cnt_next   = EW'(1);
                end
            end
            ST_SETUP: begin
                if (ev.setup_fall || tmr_reg >= TW'(SETUP_CYC - 1)) begin
                    state_next = ST_IDLE;
                end else if (any_fall) begin
                    tmr_next = tmr_reg + 1'b1;
                    buf_next = {first_index(ev.data_fall), buf_reg[PIN_LEN*3-1:3]};
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == EW'(PIN_LEN - 1)) begin
                        state_next  = ST_IDLE;
                        pin_next    = {first_index(ev.data_fall), buf_reg[PIN_LEN*3-1:3]};
                        stored_next = 1'b1;
                    end
                end
            end
            ST_ENTRY: begin
                if (any_fall) begin
                    tmr_next = '0;
                    buf_next = {first_index(ev.data_fall), buf_reg[PIN_LEN*3-1:3]};
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == EW'(PIN_LEN - 1)) begin
                        state_next = ST_IDLE;
                        if (buf_next == pin_reg) begin
                            state_next = ST_OPEN;
                        end
                    end
                end else if (tmr_reg >= TW'(GAP_CYC - 1)) begin
                    state_next = ST_IDLE;
                end
            end
            ST_OPEN: begin
                unl_next = 1'b1;
                if (tx_s2_reg || data_busy) begin
                    tmr_next = '0;
                end else if (tmr_reg >= lock_lim - 1'b1) begin
                    state_next = ST_IDLE;
                    unl_next   = 1'b0;
                end
            end
        endcase
        if (learn_ev) begin
            stored_next = 1'b0;
            state_next  = ST_IDLE;
            unl_next    = 1'b0;
        end
    end

    always_comb begin
        ind_tmr_next = '0;
        fl_tmr_next  = '0;
        flash_next   = 1'b0;
        if (ok_ev) begin
            ind_tmr_next = TW'(IND_CYC);
        end else if (ind_tmr_reg != '0) begin
            ind_tmr_next = ind_tmr_reg - 1'b1;
        end
        if (state_reg == ST_SETUP) begin
            fl_tmr_next = fl_tmr_reg + 1'b1;
            flash_next  = flash_reg;
            if (fl_tmr_reg >= TW'(FLASH_CYC - 1)) begin
                fl_tmr_next = '0;
                flash_next  = ~flash_reg;
            end
        end
        ind_next = (ind_tmr_next != '0) | flash_next;
        // Transmit only on request, unlocked or PIN-free; PIN digits never count
        txen_next = tx_s2_reg && !learn_ev && state_next != ST_SETUP &&
                    (!stored_next || state_next == ST_OPEN);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg   <= ST_IDLE;
            tmr_reg     <= '0;
            cnt_reg     <= '0;
            pin_reg     <= '0;
            buf_reg     <= '0;
            stored_reg  <= 1'b0;
            unl_reg     <= 1'b0;
            ind_tmr_reg <= '0;
            fl_tmr_reg  <= '0;
            flash_reg   <= 1'b0;
            ind_reg     <= 1'b0;
            txen_reg    <= 1'b0;
            tx_s1_reg   <= 1'b0;
            tx_s2_reg   <= 1'b0;
            sel_s1_reg  <= 1'b0;
            sel_s2_reg  <= 1'b0;
            kl_s1_reg   <= 1'b0;
            kl_s2_reg   <= 1'b0;
            ko_s1_reg   <= 1'b0;
            ko_s2_reg   <= 1'b0;
            ko_d_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            tmr_reg     <= tmr_next;
            cnt_reg     <= cnt_next;
            pin_reg     <= pin_next;
            buf_reg     <= buf_next;
            stored_reg  <= stored_next;
            unl_reg     <= unl_next;
            ind_tmr_reg <= ind_tmr_next;
            fl_tmr_reg  <= fl_tmr_next;
            flash_reg   <= flash_next;
            ind_reg     <= ind_next;
            txen_reg    <= txen_next;
            tx_s1_reg   <= transmit_req;
            tx_s2_reg   <= tx_s1_reg;
            sel_s1_reg  <= lockout_sel;
            sel_s2_reg  <= sel_s1_reg;
            kl_s1_reg   <= key_learned;
            kl_s2_reg   <= kl_s1_reg;
            ko_s1_reg   <= key_exchange_ok;
            ko_s2_reg   <= ko_s1_reg;
            ko_d_reg    <= ko_s2_reg;
        end
    end

    assign status_indicator = ind_reg;
    assign transmit_enable  = txen_reg;
    assign unlocked         = unl_reg;
    assign pin_stored       = stored_reg;

    chk_locked_no_tx: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (stored_reg && state_reg != ST_OPEN) |=> (!txen_reg || state_reg == ST_OPEN))
        else $error("Transmit while locked");
    chk_learn_erase: assert property (@(posedge ref_clk) disable iff (!reset_n)
        learn_ev |=> !stored_reg)
        else $error("PIN kept after key learn");
    chk_ind_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ok_ev && state_reg != ST_SETUP) |=> ##1 ind_reg)
        else $error("Indicator not raised after key exchange");
    chk_setup_entry: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_reg == ST_IDLE && ev.setup_fall && !learn_ev) |=> state_reg == ST_SETUP)
        else $error("Setup mode not entered");
    chk_setup_cancel: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_reg == ST_SETUP && ev.setup_fall) |=> state_reg == ST_IDLE && $stable(pin_reg))
        else $error("Setup cancel failed");
    chk_setup_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_reg == ST_SETUP && !ev.setup_fall && any_fall && !learn_ev &&
         tmr_reg < TW'(SETUP_CYC - 1) && cnt_reg == EW'(PIN_LEN - 1))
        |=> stored_reg && state_reg == ST_IDLE)
        else $error("PIN not stored on fourth entry");
    chk_gap_abort: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_reg == ST_ENTRY && !any_fall && !learn_ev && tmr_reg >= TW'(GAP_CYC - 1))
        |=> state_reg == ST_IDLE)
        else $error("Partial entry not discarded");
    chk_free_tx: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (tx_s2_reg && !stored_reg && !learn_ev && state_reg == ST_IDLE && !ev.setup_fall)
        |=> txen_reg)
        else $error("No transmit without PIN");
    chk_relock: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_reg == ST_OPEN && !tx_s2_reg && !data_busy && tmr_reg >= lock_lim - 1'b1)
        |=> state_reg == ST_IDLE)
        else $error("No relock after inactivity");
    cov_setup: cover property (@(posedge ref_clk) disable iff (!reset_n)
        state_reg == ST_SETUP ##1 stored_reg);
    cov_unlock: cover property (@(posedge ref_clk) disable iff (!reset_n)
        state_reg == ST_ENTRY ##1 state_reg == ST_OPEN);
    cov_free_tx: cover property (@(posedge ref_clk) disable iff (!reset_n)
        txen_reg && !stored_reg);
endmodule : encoder_pin_access_lock
`default_nettype wire

// File: pin_lock_pkg.sv
// Purpose: Shared constants and types for the encoder access lock
// Assumes: 100 MHz ref_clk
// Notes:   Second-scale times are derived from the clock rate
package pin_lock_pkg;
    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned DATA_W           = 8;
    localparam int unsigned PIN_LEN          = 4;
    localparam int unsigned IND_ON_S         = 1;
    localparam int unsigned SETUP_WIN_S      = 15;
    localparam int unsigned ENTRY_GAP_S      = 2;
    localparam int unsigned LOCK_LONG_S      = 900;
    localparam int unsigned LOCK_SHORT_S     = 30;
    localparam int unsigned DEBOUNCE_NS      = 1_000_000;
    localparam int unsigned FLASH_HALF_NS    = 250_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
    localparam int unsigned IND_ON_CYC       = IND_ON_S * CLK_HZ;
    localparam int unsigned SETUP_WIN_CYC    = SETUP_WIN_S * CLK_HZ;
    localparam int unsigned ENTRY_GAP_CYC    = ENTRY_GAP_S * CLK_HZ;
    localparam longint unsigned LOCK_LONG_CYC = 64'(LOCK_LONG_S) * 64'(CLK_HZ);
    localparam int unsigned LOCK_SHORT_CYC   = LOCK_SHORT_S * CLK_HZ;
    localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_NS / CLK_PERIOD_NS;
    localparam int unsigned FLASH_HALF_CYC   = FLASH_HALF_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [DATA_W-1:0] data_fall;
        logic              setup_fall;
    } key_events_t;
endpackage : pin_lock_pkg

// File: input_conditioner.sv
// Purpose: Synchronise, debounce and detect releases of one input
// Assumes: Input is asynchronous to ref_clk
// Notes:   fall pulses one cycle when a stable high returns low
`timescale 1ns/1ps
`default_nettype none
module input_conditioner #(
    parameter int unsigned DEB_CYC = 100_000
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic pin_in,
    output var  logic level,
    output var  logic fall
);
    if (DEB_CYC < 1) begin : g_bad_deb
        $error("DEB_CYC must be at least 1");
    end
    localparam int unsigned CW = $clog2(DEB_CYC + 1);
    logic          sync1_reg, sync2_reg, level_reg, level_next, fall_reg, fall_next;
    logic [CW-1:0] cnt_reg, cnt_next;

    always_comb begin
        level_next = level_reg;
        cnt_next   = cnt_reg;
        fall_next  = 1'b0;
        if (sync2_reg == level_reg) begin
            cnt_next = '0;
        end else if (cnt_reg == CW'(DEB_CYC - 1)) begin
            cnt_next   = '0;
            level_next = sync2_reg;
            fall_next  = level_reg;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            level_reg <= 1'b0;
            fall_reg  <= 1'b0;
            cnt_reg   <= '0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            level_reg <= level_next;
            fall_reg  <= fall_next;
            cnt_reg   <= cnt_next;
        end
    end
    assign level = level_reg;
    assign fall  = fall_reg;
endmodule : input_conditioner
`default_nettype wire

// File: user_side_model.sv
// Purpose: Pushbuttons and decoder link seen by the access lock
// Assumes: Lines change on the falling ref_clk edge
// Notes:   Released lines fall back to their pull-down level
`timescale 1ns/1ps
`default_nettype none
module user_side_model
    import pin_lock_pkg::*;
(
    input  wire logic              ref_clk,
    output var  logic [DATA_W-1:0] data_in,
    output var  logic              pin_setup_req,
    output var  logic              transmit_req,
    output var  logic              key_learned,
    output var  logic              key_exchange_ok
);
    localparam int HOLD = 8;

    initial begin
        data_in = '0;
        pin_setup_req = 1'b0;
        transmit_req = 1'b0;
        key_learned = 1'b0;
        key_exchange_ok = 1'b0;
    end

    // One entry: a button held well past debounce, then released
    task automatic press_data(input logic [2:0] idx);
        @(negedge ref_clk) data_in[idx] = 1'b1;
        repeat (HOLD) @(negedge ref_clk);
        data_in = '0;
        repeat (HOLD) @(negedge ref_clk);
    endtask : press_data

    task automatic press_setup();
        @(negedge ref_clk) pin_setup_req = 1'b1;
        repeat (HOLD) @(negedge ref_clk);
        pin_setup_req = 1'b0;
        repeat (HOLD) @(negedge ref_clk);
    endtask : press_setup

    // Level lines: 0 send request, 1 key learned, 2 exchange done
    task automatic set_line(input int sel, input logic v);
        @(negedge ref_clk);
        case (sel)
            0: transmit_req = v;
            1: key_learned = v;
            default: key_exchange_ok = v;
        endcase
    endtask : set_line
endmodule : user_side_model
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the encoder access lock
// Assumes: Shortened timing parameters on the lock
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pin_lock_pkg::*;
    localparam int SEC = 20, IND = IND_ON_S * SEC, SETUP = SETUP_WIN_S * SEC;
    localparam int GAP = ENTRY_GAP_S * SEC, SHORT = LOCK_SHORT_S * SEC, LONG = LOCK_LONG_S * SEC;
    localparam logic [11:0] PIN = {3'h7, 3'h5, 3'h1, 3'h1};
    localparam logic [11:0] BAD = {3'h3, 3'h2, 3'h1, 3'h0};
    logic              ref_clk, reset_n, lockout_sel;
    logic [DATA_W-1:0] data_in;
    logic              pin_setup_req, transmit_req, key_learned, key_exchange_ok;
    logic              status_indicator, transmit_enable, unlocked, pin_stored;
    int                err_total, comparisons, cycles, h, t, x;

    user_side_model user_i (.ref_clk(ref_clk), .data_in(data_in),
        .pin_setup_req(pin_setup_req), .transmit_req(transmit_req),
        .key_learned(key_learned), .key_exchange_ok(key_exchange_ok));

    encoder_pin_access_lock #(.DEB_CYC(2), .FLASH_CYC(4), .SEC_CYC(SEC))
    encoder_pin_access_lock_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .data_in(data_in), .pin_setup_req(pin_setup_req),
        .transmit_req(transmit_req), .lockout_sel(lockout_sel),
        .key_learned(key_learned), .key_exchange_ok(key_exchange_ok),
        .status_indicator(status_indicator), .transmit_enable(transmit_enable),
        .unlocked(unlocked), .pin_stored(pin_stored));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Counts indicator high cycles, indicator changes and enabled cycles
    task automatic watch(input int n);
        logic last;
        h = 0;
        t = 0;
        x = 0;
        last = status_indicator;
        repeat (n) begin
            @(negedge ref_clk);
            h += int'(status_indicator === 1'b1);
            t += int'(status_indicator !== last);
            x += int'(transmit_enable === 1'b1);
            last = status_indicator;
        end
    endtask : watch

    task automatic enter(input logic [11:0] code);
        for (int i = 0; i < 4; i++) user_i.press_data(code[3*i +: 3]);
        watch(6);
    endtask : enter

    task automatic t_exchange();
        user_i.set_line(2, 1'b1);
        watch(IND + 20);
        check(h, IND);
        check(status_indicator, 1'b0);
        user_i.set_line(2, 1'b0);
    endtask : t_exchange

    task automatic t_send_free();
        user_i.set_line(0, 1'b1);
        watch(10);
        check(transmit_enable, 1'b1);
        user_i.set_line(0, 1'b0);
        watch(10);
        check(transmit_enable, 1'b0);
    endtask : t_send_free

    task automatic t_cancel(input logic by_timeout);
        user_i.press_setup();
        watch(24);
        check(t >= 2, 1'b1);
        user_i.press_data(3'h0);
        user_i.press_data(3'h6);
        if (by_timeout) watch(SETUP);
        else user_i.press_setup();
        watch(6);
        watch(24);
        check(t, 0);
        check(status_indicator, 1'b0);
        check(pin_stored, 1'b0);
    endtask : t_cancel

    task automatic t_store();
        user_i.press_setup();
        enter(PIN);
        watch(24);
        check(t, 0);
        check(h, 0);
        check(pin_stored, 1'b1);
        check(unlocked, 1'b0);
    endtask : t_store

    task automatic t_locked();
        user_i.set_line(0, 1'b1);
        watch(20);
        check(x, 0);
        user_i.set_line(0, 1'b0);
        fork
            for (int i = 0; i < 4; i++) user_i.press_data(BAD[3*i +: 3]);
            watch(70);
        join
        check(x, 0);
        check(unlocked, 1'b0);
        user_i.press_data(3'h1);
        user_i.press_data(3'h1);
        watch(GAP + 20);
        user_i.press_data(3'h5);
        user_i.press_data(3'h7);
        watch(6);
        check(unlocked, 1'b0);
        watch(GAP + 20);
    endtask : t_locked

    task automatic t_relock(input logic sel, input int idle);
        @(negedge ref_clk) lockout_sel = sel;
        enter(PIN);
        check(unlocked, 1'b1);
        user_i.set_line(0, 1'b1);
        watch(10);
        check(transmit_enable, 1'b1);
        user_i.set_line(0, 1'b0);
        watch(idle - 30);
        check(unlocked, 1'b1);
        watch(60);
        check(unlocked, 1'b0);
    endtask : t_relock

    task automatic t_erase();
        user_i.set_line(1, 1'b1);
        watch(6);
        user_i.set_line(1, 1'b0);
        watch(6);
        check(pin_stored, 1'b0);
        t_send_free();
    endtask : t_erase

    initial begin
        reset_n = 1'b0;
        lockout_sel = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        check({status_indicator, transmit_enable, unlocked, pin_stored}, 4'h0);
        t_exchange();
        t_send_free();
        t_cancel(1'b0);
        t_cancel(1'b1);
        t_store();
        t_locked();
        t_relock(1'b1, SHORT);
        t_relock(1'b0, LONG);
        t_erase();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
